// [adc_ctrl_regs.sv]
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_ctrl_regs
   import adc_pkg::*;
#(
   parameter int RESET_CYCLES = 4
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire logic              req_valid,
   input  wire adc_req_type       req,
   output logic [7:0]             rdata,
   output logic                   rdata_valid,
   output logic [7:0]             channel4_gain_code,
   output logic                   channel4_muted,
   output logic [7:0]             channel4_atten_half_db,
   output adc_dac_ctl_type        dac_ctl,
   output adc_port_ctl_type       port_ctl,
   output logic [3:0]             channel_data_enable,
   output logic [3:0]             channel_output_enable,
   output logic                   logic_reset_active
);
   // Refuses a reset length that the four-bit counter cannot hold.
   if (RESET_CYCLES < 1 || RESET_CYCLES > 15) begin : g_bad_cycles
      $error("RESET_CYCLES must lie in 1..15.");
   end

   typedef enum logic [1:0] {
      ADC_ST_RUN   = 2'b00,
      ADC_ST_RESET = 2'b01
   } adc_state_type;

   adc_state_type state_r, state_nxt;
   logic [3:0]    rst_cnt_r, rst_cnt_nxt;
   logic [7:0]    gain_r, gain_nxt;
   logic [7:0]    func_r, func_nxt;
   logic [7:0]    sys_r, sys_nxt;
   logic [7:0]    ser_r, ser_nxt;
   logic [7:0]    rdata_r, rdata_nxt;
   logic          rvalid_r, rvalid_nxt;
   logic          wr_soft_reset;
   adc_rate_type  rate;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   always_comb begin
      state_nxt     = state_r;
      rst_cnt_nxt   = rst_cnt_r;
      gain_nxt      = gain_r;
      func_nxt      = func_r;
      sys_nxt       = sys_r;
      ser_nxt       = ser_r;
      rdata_nxt     = rdata_r;
      rvalid_nxt    = 1'b0;
      wr_soft_reset = req_valid && req.write
                      && hit(req.addr, `ADC_OFF_SYSTEM)
                      && req.wdata[`ADC_BIT_SOFT_RESET];
      case (state_r)
         ADC_ST_RUN: begin
            if (req_valid && req.write) begin
               if (hit(req.addr, `ADC_OFF_CH4_GAIN)) begin
                  gain_nxt = req.wdata;
               end
               if (hit(req.addr, `ADC_OFF_FUNCTION)) begin
                  func_nxt = req.wdata & `ADC_MASK_FUNCTION;
               end
               if (hit(req.addr, `ADC_OFF_SYSTEM)) begin
                  sys_nxt = req.wdata & `ADC_MASK_SYSTEM;
               end
               if (hit(req.addr, `ADC_OFF_SERIAL)) begin
                  ser_nxt = req.wdata & `ADC_MASK_SERIAL;
               end
            end else if (req_valid) begin
               rvalid_nxt = 1'b1;
               if (hit(req.addr, `ADC_OFF_CH4_GAIN)) begin
                  rdata_nxt = gain_r;
               end else if (hit(req.addr, `ADC_OFF_FUNCTION)) begin
                  rdata_nxt = func_r;
               end else if (hit(req.addr, `ADC_OFF_SYSTEM)) begin
                  rdata_nxt = sys_r;
               end else if (hit(req.addr, `ADC_OFF_SERIAL)) begin
                  rdata_nxt = ser_r;
               end else begin
                  rdata_nxt = 8'h00;
               end
            end
            if (wr_soft_reset) begin
               state_nxt   = ADC_ST_RESET;
               rst_cnt_nxt = 4'(RESET_CYCLES);
               // Registers take reset values from the first reset cycle.
               gain_nxt    = `ADC_RST_CH4_GAIN;
               func_nxt    = `ADC_RST_FUNCTION;
               sys_nxt     = `ADC_RST_SYSTEM;
               ser_nxt     = `ADC_RST_SERIAL;
            end
         end
         ADC_ST_RESET: begin
            gain_nxt  = `ADC_RST_CH4_GAIN;
            func_nxt  = `ADC_RST_FUNCTION;
            sys_nxt   = `ADC_RST_SYSTEM;
            ser_nxt   = `ADC_RST_SERIAL;
            rdata_nxt = 8'h00;
            if (rst_cnt_r <= 4'h1) begin
               state_nxt   = ADC_ST_RUN;
               rst_cnt_nxt = 4'h0;
            end else begin
               rst_cnt_nxt = rst_cnt_r - 4'h1;
            end
         end
         default: begin
            state_nxt   = ADC_ST_RUN;
            rst_cnt_nxt = 4'h0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= ADC_ST_RUN;
         rst_cnt_r <= 4'h0;
         gain_r    <= `ADC_RST_CH4_GAIN;
         func_r    <= `ADC_RST_FUNCTION;
         sys_r     <= `ADC_RST_SYSTEM;
         ser_r     <= `ADC_RST_SERIAL;
         rdata_r   <= 8'h00;
         rvalid_r  <= 1'b0;
      end else if (clk_en) begin
         state_r   <= state_nxt;
         rst_cnt_r <= rst_cnt_nxt;
         gain_r    <= gain_nxt;
         func_r    <= func_nxt;
         sys_r     <= sys_nxt;
         ser_r     <= ser_nxt;
         rdata_r   <= rdata_nxt;
         rvalid_r  <= rvalid_nxt;
      end
   end

   adc_gain_decode u_gain (
      .code          (gain_r),
      .muted         (channel4_muted),
      .atten_half_db (channel4_atten_half_db)
   );

   adc_port_decode u_port (
      .serial_reg (ser_r),
      .port_ctl   (port_ctl)
   );

   always_comb begin
      rate                   = adc_rate_type'(sys_r[1:0]);
      dac_ctl.rate           = rate;
      dac_ctl.deemph_curve   = func_r[1:0];
      dac_ctl.deemph_active  = (rate == ADC_RATE_SINGLE)
                               && (func_r[1:0] != ADC_DEEMPH_OFF);
      dac_ctl.invert_phase   = func_r[2];
      dac_ctl.zero_data_mute = func_r[3];
      dac_ctl.channel_mute   = func_r[7:4];
      dac_ctl.pair_powerdown = sys_r[3:2];
      logic_reset_active     = (state_r == ADC_ST_RESET);
   end

   // Each channel follows the power-down bit of its pair.
   for (genvar ch = 0; ch < 4; ch++) begin : g_chan_en
      assign channel_data_enable[ch]   = ~sys_r[2 + ch / 2];
      assign channel_output_enable[ch] = ~sys_r[2 + ch / 2];
   end

   assign channel4_gain_code = gain_r;
   assign rdata              = rdata_r;
   assign rdata_valid        = rvalid_r;
endmodule : adc_ctrl_regs

// [adc_ctrl_regs_props.sv]
`timescale 1ns/1ps
module adc_props
   import adc_pkg::*;
#(
   parameter int RESET_CYCLES = 4
)
(
   input wire logic            clk_sys,
   input wire logic            rst_n,
   input wire logic            clk_en,
   input wire logic            req_valid,
   input wire adc_req_type     req,
   input wire logic            rdata_valid,
   input wire logic [7:0]      channel4_gain_code,
   input wire logic            channel4_muted,
   input wire logic [7:0]      channel4_atten_half_db,
   input wire adc_dac_ctl_type dac_ctl,
   input wire logic [3:0]      channel_output_enable,
   input wire logic            logic_reset_active
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic       go;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   assign go = clk_en && req_valid && !logic_reset_active;
   // Counts the cycles that the soft reset sequence stays active.
   always_comb begin
      cnt_nxt = cnt_r;
      if (!logic_reset_active) cnt_nxt = 4'h0;
      else if (clk_en) cnt_nxt = cnt_r + 4'h1;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) cnt_r <= 4'h0;
      else cnt_r <= cnt_nxt;
   end
   property p_rd; go && !req.write |=> rdata_valid; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_mute;
      channel4_muted == (channel4_gain_code < 8'h10);
   endproperty
   a_mute: assert property (p_mute) else $error("mute decode wrong");
   property p_att;
      !channel4_muted |-> channel4_atten_half_db == 8'hff - channel4_gain_code;
   endproperty
   a_att: assert property (p_att) else $error("attenuation wrong");
   property p_dem;
      dac_ctl.deemph_active ==
         (dac_ctl.deemph_curve != 2'h0 && dac_ctl.rate == ADC_RATE_SINGLE);
   endproperty
   a_dem: assert property (p_dem) else $error("deemphasis wrong");
   property p_pwr;
      channel_output_enable == {{2{!dac_ctl.pair_powerdown[1]}},
                                {2{!dac_ctl.pair_powerdown[0]}}};
   endproperty
   a_pwr: assert property (p_pwr) else $error("enable wrong");
   property p_sr;
      go && req.write && req.addr == 4'h6 && req.wdata[7] |=>
         logic_reset_active;
   endproperty
   a_sr: assert property (p_sr) else $error("soft reset not started");
   property p_len;
      $fell(logic_reset_active) |-> cnt_r == RESET_CYCLES;
   endproperty
   a_len: assert property (p_len) else $error("reset length wrong");
   property p_rst;
      logic_reset_active |-> channel4_gain_code == 8'hff && dac_ctl == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : adc_props

// [adc_gain_decode.sv]
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_gain_decode
   import adc_pkg::*;
(
   input  wire logic [7:0] code,
   output logic            muted,
   output logic [7:0]      atten_half_db
);
   always_comb begin
      muted         = (code < `ADC_MUTE_LIMIT);
      atten_half_db = muted ? 8'h00 : (`ADC_GAIN_FULL - code);
   end
endmodule : adc_gain_decode

// [adc_host_model.sv]
`timescale 1ns/1ps
module adc_host
   import adc_pkg::*;
(
   input  wire logic   clk_sys,
   output logic        req_valid,
   output adc_req_type req
);
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // A request is launched after an edge and held through the next one.
   task automatic put(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      req_valid = 1'b1;
      req = {w, a, d};
   endtask : put
   // A released bus shows the inverse of its last value.
   task automatic idle();
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      req = ~req;
   endtask : idle
endmodule : adc_host

// [adc_pkg.sv]
package adc_pkg;
   typedef enum logic [1:0] {
      ADC_RATE_SINGLE = 2'b00,
      ADC_RATE_DUAL   = 2'b01,
      ADC_RATE_QUAD   = 2'b10,
      ADC_RATE_UNUSED = 2'b11
   } adc_rate_type;
   typedef enum logic [1:0] {
      ADC_DEEMPH_OFF = 2'b00,
      ADC_DEEMPH_48K = 2'b01,
      ADC_DEEMPH_44K = 2'b10,
      ADC_DEEMPH_32K = 2'b11
   } adc_deemph_type;
   typedef enum logic [2:0] {
      ADC_FMT_LJ24  = 3'b000,
      ADC_FMT_I2S24 = 3'b001,
      ADC_FMT_TDM0  = 3'b010,
      ADC_FMT_TDM1  = 3'b011,
      ADC_FMT_RJ24  = 3'b100,
      ADC_FMT_RJ20  = 3'b101,
      ADC_FMT_RJ18  = 3'b110,
      ADC_FMT_RJ16  = 3'b111
   } adc_fmt_type;
   typedef struct packed {
      logic       write;
      logic [3:0] addr;
      logic [7:0] wdata;
   } adc_req_type;
   typedef struct packed {
      logic [1:0] pair_powerdown;
      logic [3:0] channel_mute;
      logic       invert_phase;
      logic       zero_data_mute;
      logic       deemph_active;
      logic [1:0] deemph_curve;
      adc_rate_type rate;
   } adc_dac_ctl_type;
   typedef struct packed {
      logic       tdm;
      logic       tdm_delay;
      logic [4:0] word_bits;
      logic       left_justified;
      logic       i2s;
      logic       frame_clock_polarity;
      logic       bit_clock_edge;
   } adc_port_ctl_type;
endpackage : adc_pkg

// [adc_port_decode.sv]
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_port_decode
   import adc_pkg::*;
(
   input  wire logic [7:0]       serial_reg,
   output adc_port_ctl_type      port_ctl
);
   adc_fmt_type fmt;
   always_comb begin
      fmt = adc_fmt_type'(serial_reg[2:0]);
      port_ctl = '0;
      port_ctl.frame_clock_polarity = serial_reg[4];
      port_ctl.bit_clock_edge       = serial_reg[5];
      case (fmt)
         ADC_FMT_LJ24: begin
            port_ctl.left_justified = 1'b1;
            port_ctl.word_bits      = 5'd24;
         end
         ADC_FMT_I2S24: begin
            port_ctl.i2s       = 1'b1;
            port_ctl.word_bits = 5'd24;
         end
         ADC_FMT_TDM0: begin
            port_ctl.tdm       = 1'b1;
            port_ctl.word_bits = 5'd24;
         end
         ADC_FMT_TDM1: begin
            port_ctl.tdm       = 1'b1;
            port_ctl.tdm_delay = 1'b1;
            port_ctl.word_bits = 5'd24;
         end
         ADC_FMT_RJ24: port_ctl.word_bits = 5'd24;
         ADC_FMT_RJ20: port_ctl.word_bits = 5'd20;
         ADC_FMT_RJ18: port_ctl.word_bits = 5'd18;
         ADC_FMT_RJ16: port_ctl.word_bits = 5'd16;
         default:      port_ctl.word_bits = 5'd24;
      endcase
   end
endmodule : adc_port_decode

// [adc_regs.svh]
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
`define ADC_OFF_CH4_GAIN    4'h4
`define ADC_OFF_FUNCTION    4'h5
`define ADC_OFF_SYSTEM      4'h6
`define ADC_OFF_SERIAL      4'h7
`define ADC_RST_CH4_GAIN    8'hff
`define ADC_RST_FUNCTION    8'h00
`define ADC_RST_SYSTEM      8'h00
`define ADC_RST_SERIAL      8'h00
`define ADC_MASK_FUNCTION   8'hff
`define ADC_MASK_SYSTEM     8'h0f
`define ADC_MASK_SERIAL     8'h37
`define ADC_BIT_SOFT_RESET  7
`define ADC_MUTE_LIMIT      8'h10
`define ADC_GAIN_FULL       8'hff
`define ADC_RESET_PULSE     4'h4
`endif

// [testbench.sv]
`timescale 1ns/1ps
module testbench
   import adc_pkg::*;
;
   localparam int    RC = 3;
   logic             clk_sys = 1'b0;
   logic             rst_n = 1'b0;
   logic             req_valid, rv, mu, lra;
   adc_req_type      req;
   logic [7:0]       rdat, g4, at, f, s, p;
   adc_dac_ctl_type  dc;
   adc_port_ctl_type pc;
   logic [3:0]       den, oen;
   logic [7:0]       expq[$];
   logic [7:0]       gt[4] = '{8'h00, 8'h0f, 8'h10, 8'hff};
   logic [4:0]       wbt[8] = '{5'h18, 5'h18, 5'h00, 5'h00,
                                5'h18, 5'h14, 5'h12, 5'h10};
   int               mismatches = 0;
   int               n_checks = 0;
   int               i;
   initial forever #12.5 clk_sys = ~clk_sys;
   adc_ctrl_regs #(.RESET_CYCLES(RC)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
      .req_valid(req_valid), .req(req), .rdata(rdat), .rdata_valid(rv),
      .channel4_gain_code(g4), .channel4_muted(mu),
      .channel4_atten_half_db(at), .dac_ctl(dc), .port_ctl(pc),
      .channel_data_enable(den), .channel_output_enable(oen),
      .logic_reset_active(lra));
   adc_host h (.clk_sys(clk_sys), .req_valid(req_valid), .req(req));
   task automatic chk(input string n, input logic [7:0] e, g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      h.put(1'b0, a, 8'h00);
      expq.push_back(e);
   endtask : rd
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   always @(negedge clk_sys) begin
      if (rv === 1'b1 && expq.size() == 0) chk("rdata", 8'h00, 8'h01);
      else if (rv === 1'b1) chk("rdata", expq.pop_front(), rdat);
   end
   initial begin
      i = $urandom(32'h6548);
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      for (i = 0; i < 5; i++) rd(4'(i + 4), i == 0 ? 8'hff : 8'h00);
      for (i = 0; i < 5; i++) begin
         f = i == 4 ? 8'($urandom) : gt[i];
         h.put(1'b1, 4'h4, f);
         rd(4'h4, f);
         h.idle();
         chk("muted", {7'h0, f < 8'h10}, {7'h0, mu});
         chk("atten", f < 8'h10 ? 8'h00 : 8'hff - f, at);
         chk("gain", f, g4);
      end
      for (i = 0; i < 4; i++) begin
         f = 8'($urandom);
         s = {4'h0, 2'($urandom), 2'(i)};
         h.put(1'b1, 4'h5, f);
         h.put(1'b1, 4'h6, s | 8'h70);
         rd(4'h5, f);
         rd(4'h6, s);
         h.idle();
         chk("func", f, {dc.channel_mute, dc.zero_data_mute,
                         dc.invert_phase, dc.deemph_curve});
         chk("rate", {6'h0, 2'(i)}, {6'h0, dc.rate});
         chk("dem", {7'h0, f[1:0] != 2'h0 && i == 0},
                    {7'h0, dc.deemph_active});
         chk("enable", ~{2{s[3], s[3], s[2], s[2]}}, {den, oen});
      end
      for (i = 0; i < 8; i++) begin
         p = {2'h0, 2'($urandom), 1'b0, 3'(i)};
         h.put(1'b1, 4'h7, p | 8'hc8);
         rd(4'h7, p);
         h.idle();
         chk("edge", {6'h0, p[5:4]},
                     {6'h0, pc.bit_clock_edge, pc.frame_clock_polarity});
         if (i == 2 || i == 3) chk("tdm", {6'h0, 1'b1, i[0]},
                                   {6'h0, pc.tdm, pc.tdm_delay});
         else chk("fmt", {i == 0, i == 1, 1'b0, wbt[i]},
                         {pc.left_justified, pc.i2s, pc.tdm, pc.word_bits});
      end
      h.put(1'b1, 4'h5, 8'hf0);
      h.put(1'b1, 4'h6, 8'h8c);
      h.put(1'b1, 4'h4, 8'h33);
      h.idle();
      chk("rst on", 8'h01, {7'h0, lra});
      for (i = 0; lra === 1'b1 && i < 20; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk("rst len", 8'(RC - 1), 8'(i));
      rd(4'h4, 8'hff);
      rd(4'h5, 8'h00);
      rd(4'h6, 8'h00);
      h.idle();
      for (i = 0; expq.size() > 0 && i < 20; i++) @(posedge clk_sys);
      if (expq.size() > 0) chk("drain", 8'h00, 8'h01);
      end_of_test();
   end
endmodule : testbench
bind adc_ctrl_regs adc_props #(.RESET_CYCLES(RESET_CYCLES)) u_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
   .req_valid(req_valid), .req(req), .rdata_valid(rdata_valid),
   .channel4_gain_code(channel4_gain_code),
   .channel4_muted(channel4_muted),
   .channel4_atten_half_db(channel4_atten_half_db), .dac_ctl(dac_ctl),
   .channel_output_enable(channel_output_enable),
   .logic_reset_active(logic_reset_active));
